//--- bench/pwm_load_model.sv
// load model resolving the pin b lines seen by the power stage
`timescale 1ns/1ps
module pwm_load_model (
    // clock
    input wire logic        pclk,
    // pins from the timer
    input wire logic [4:0]  chan_pin_b,
    input wire logic [4:0]  chan_pin_b_oe_n,
    // resolved lines
    output logic     [4:0]  pin_b_line
);
    logic [4:0] last_ff = 5'h0;
    always @(posedge pclk) begin
        last_ff <= pin_b_line;
    end
    // no pull on these lines: a released line must not look like a held level
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_b_line[i] = chan_pin_b_oe_n[i] ? ~last_ff[i] : chan_pin_b[i];
        end
    end
endmodule // pwm_load_model

//--- bench/timer_pwm_bench.sv
// self-checking bench for the timer pwm block
`timescale 1ns/1ps
module timer_pwm_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  ext_clk_in;
    logic [4:0]  chan_pin_a;
    logic [4:0]  chan_pin_b;
    logic [4:0]  chan_pin_b_oe_n;
    logic        ch4_aux_out_a;
    logic        ch4_aux_out_b;
    logic [4:0]  pin_b_line;
    logic [32:0] exp_q [$];
    logic [35:0] h [8];
    logic [7:0]  s;
    logic [15:0] v;
    int          rs_exp [8] = '{0, 0, 12, 8, 8, 4, 12, 16};
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          seed;

    timer_pwm u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_in(ext_clk_in), .chan_pin_a(chan_pin_a), .chan_pin_b(chan_pin_b),
        .chan_pin_b_oe_n(chan_pin_b_oe_n), .ch4_aux_out_a(ch4_aux_out_a),
        .ch4_aux_out_b(ch4_aux_out_b));
    pwm_load_model u_load (.pclk(pclk), .chan_pin_b(chan_pin_b),
        .chan_pin_b_oe_n(chan_pin_b_oe_n), .pin_b_line(pin_b_line));

    // ----------------------------------------------
    // tasks
    // ----------------------------------------------
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one setup, then access held until ready; a spare cycle keeps drives apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic measure(input int n);
        for (int k = 0; k < 8; k++) h[k] = 36'h0;
        repeat (n) begin
            @(posedge pclk);
            s = {ch4_aux_out_b, ch4_aux_out_a, chan_pin_b[4:3], chan_pin_a[4:3], chan_pin_a[1:0]};
            for (int k = 0; k < 8; k++) h[k] += 36'(s[k]);
        end
    endtask

    // ----------------------------------------------
    // clock, watchdog and read monitor
    // ----------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check(36'({pslverr, prdata}), 36'(exp_q.pop_front()));
        end
    end

    initial begin
        seed = 63943;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_clk_in = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(36'(chan_pin_b_oe_n), 36'h1F);
        rd(8'h2C, 33'hFFFF);
        rd(8'hFC, 33'h1_0000_0000);
        rd(8'h34, 33'h1_0000_0000);
        wr(8'h04, 32'h7);
        v = 16'($random(seed));
        wr(8'h48, {16'h0, v});
        rd(8'h28, {17'h0, v});
        rd(8'h68, {17'h0, v});
        rd(8'h88, 33'h0);
        // ch0 clears on b, ch1 follows by sync clear, ch2 counts external edges
        wr(8'h04, 32'h3);
        wr(8'h20, 32'h40);
        wr(8'h40, 32'h60);
        wr(8'h2C, 32'h4);
        wr(8'h30, 32'hA);
        wr(8'h4C, 32'h4);
        wr(8'h50, 32'hA);
        wr(8'h28, 32'h0);
        wr(8'h68, 32'h0);
        wr(8'h60, 32'h4);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h7);
        repeat (10) begin
            ext_clk_in[0] <= ~ext_clk_in[0];
            repeat (4) @(posedge pclk);
        end
        measure(22);
        check(h[0], 36'd12);
        check(h[1], 36'd12);
        rd(8'h68, 33'h5);
        wr(8'h2C, 32'hC);
        repeat (30) @(posedge pclk);
        measure(22);
        check(h[0], 36'd0);
        wr(8'h20, 32'h20);
        wr(8'h30, 32'hE);
        repeat (30) @(posedge pclk);
        measure(22);
        check(h[0], 36'd22);
        wr(8'h00, 32'h0);
        wr(8'h28, 32'h55);
        measure(10);
        check(h[0], 36'd10);
        rd(8'h28, 33'h55);
        wr(8'h2C, 32'h5);
        wr(8'h30, 32'h5);
        wr(8'h20, 32'h40);
        wr(8'h28, 32'h0);
        wr(8'h00, 32'h1);
        repeat (20) @(posedge pclk);
        measure(22);
        check(h[0], 36'd22);
        // reset-synchronized pairs, period of ten counts
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h8C, 32'h9);
        wr(8'h90, 32'h3);
        wr(8'hAC, 32'h5);
        wr(8'hB0, 32'h7);
        wr(8'h88, 32'h0);
        wr(8'h08, 32'h1A0);
        wr(8'h00, 32'h18);
        repeat (30) @(posedge pclk);
        measure(20);
        for (int k = 2; k < 8; k++) check(h[k], 36'(rs_exp[k]));
        check({35'h0, pin_b_line[3]}, {35'h0, ~chan_pin_a[3]});
        wr(8'h08, 32'h120);
        measure(20);
        check(h[2], 36'd8);
        check(h[4], 36'd12);
        // ch3 and ch4 buffers differ so a crossed copy shows
        wr(8'h94, 32'h9);
        wr(8'h98, 32'h6);
        wr(8'hB4, 32'h5);
        wr(8'hB8, 32'h7);
        wr(8'h08, 32'h160);
        repeat (20) @(posedge pclk);
        rd(8'h90, 33'h6);
        rd(8'hB0, 33'h7);
        // ch4 set to clear on a: it must still count past gen a, eight ticks
        wr(8'hA0, 32'h20);
        wr(8'h00, 32'h0);
        wr(8'hA8, 32'h0);
        wr(8'h00, 32'h10);
        rd(8'h00, 33'h10);
        wr(8'h00, 32'h0);
        rd(8'hA8, 33'h8);
        end_of_test();
    end
endmodule // timer_pwm_bench

//--- bench/timer_pwm_properties.sv
// assertion checker for the timer block apb and pin ports
`timescale 1ns/1ps
module timer_pwm_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic [4:0]  chan_pin_a,
    input wire logic [4:0]  chan_pin_b,
    input wire logic [4:0]  chan_pin_b_oe_n,
    input wire logic        ch4_aux_out_a,
    input wire logic        ch4_aux_out_b
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------
    // apb handshake
    // ----------------------------------------------
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready one cycle after access");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved outside a read");
    // ----------------------------------------------
    // pin pairs
    // ----------------------------------------------
    pair_two_a: assert property ($changed(ch4_aux_out_a) |-> ch4_aux_out_a != chan_pin_a[4])
        else $error("pair two not complementary");
    pair_three_a: assert property ($changed(ch4_aux_out_b) |-> ch4_aux_out_b != chan_pin_b[4])
        else $error("pair three not complementary");
    pin_b_driven_a: assert property ($changed(chan_pin_b[3]) |-> !chan_pin_b_oe_n[3])
        else $error("pin b moved while undriven");
    cover property (pslverr);
    cover property (pready && pwrite);
    cover property ($changed(ch4_aux_out_b));
endmodule // timer_pwm_properties

bind timer_pwm timer_pwm_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_pin_a(chan_pin_a),
    .chan_pin_b(chan_pin_b), .chan_pin_b_oe_n(chan_pin_b_oe_n),
    .ch4_aux_out_a(ch4_aux_out_a), .ch4_aux_out_b(ch4_aux_out_b)
);

//--- design/timer_pwm.v
// five-channel 16-bit timer with synchronization, pwm and reset-synchronized pwm
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "timer_pwm_defines.vh"

module timer_pwm #(
    parameter NCH = 5
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // external count clocks
    input  wire [3:0]  ext_clk_in,
    // timer pins
    output reg  [4:0]  chan_pin_a,
    output reg  [4:0]  chan_pin_b,
    output reg  [4:0]  chan_pin_b_oe_n,
    output reg         ch4_aux_out_a,
    output reg         ch4_aux_out_b
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg  [4:0]  run_ff;
    reg  [4:0]  sync_ff;
    reg  [8:0]  mode_ff;
    reg  [6:0]  ctrl_ff   [0:4];
    reg  [3:0]  io_ff     [0:4];
    reg  [15:0] cnt_ff    [0:4];
    reg  [15:0] gra_ff    [0:4];
    reg  [15:0] grb_ff    [0:4];
    reg  [15:0] bufa_ff   [0:1];
    reg  [15:0] bufb_ff   [0:1];
    reg  [4:0]  wave_a_ff;
    reg  [4:0]  wave_b_ff;
    reg  [2:0]  pair_ff;
    reg  [2:0]  div_ff;
    reg  [3:0]  ext_s1_ff;
    reg  [3:0]  ext_s2_ff;
    reg  [3:0]  ext_s3_ff;

    reg  [15:0] nxt_cnt   [0:4];
    reg  [15:0] nxt_gra   [0:4];
    reg  [15:0] nxt_grb   [0:4];
    reg  [4:0]  nxt_wave_a;
    reg  [4:0]  nxt_wave_b;
    reg  [2:0]  nxt_pair;
    reg  [4:0]  nxt_pin_a;
    reg  [4:0]  nxt_pin_b;
    reg  [4:0]  nxt_oe_n;
    reg         nxt_aux_a;
    reg         nxt_aux_b;
    reg  [4:0]  tick;
    reg  [4:0]  match_a;
    reg  [4:0]  match_b;
    reg  [4:0]  own_clr;
    reg  [4:0]  clr;
    reg         sync_clr;
    reg  [31:0] rd_data;
    reg         rd_err;
    reg  [2:0]  psc;
    reg  [1:0]  act;
    reg         pair_t2;
    reg         pair_t3;
    integer     c;
    integer     r;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire        rs_mode  = mode_ff[`MODE_RSPWM_BIT];
    wire        buf_en   = mode_ff[`MODE_BUF_BIT];
    wire [2:0]  blk      = paddr[7:5];
    wire [2:0]  idx      = paddr[4:2];
    wire [2:0]  ch       = blk - 3'h1;
    wire        is_glob  = (blk == 3'h0);
    wire        is_chan  = (blk != 3'h0) && (blk <= 3'h5);
    wire        has_buf  = (ch == 3'h3) || (ch == 3'h4);
    wire        bsel     = (ch == 3'h4);
    // write lands on the edge where the master sees pready high
    wire        wr       = psel && penable && pwrite && pready && (paddr[1:0] == 2'h0);
    wire        ch_wr    = wr && is_chan;
    wire [4:0]  ch_onehot = is_chan ? (5'h01 << ch) : 5'h00;

    // ---------------------------------------------------------------
    // count clock selection
    // ---------------------------------------------------------------
    function ext_edge;
        input       s2;
        input       s3;
        input [1:0] sel;
        begin
            if (sel == `EDGE_RISE) begin
                ext_edge = s2 & ~s3;
            end else if (sel == `EDGE_FALL) begin
                ext_edge = ~s2 & s3;
            end else begin
                ext_edge = s2 ^ s3;
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always @* begin
        nxt_wave_a = wave_a_ff;
        nxt_wave_b = wave_b_ff;
        nxt_pair   = pair_ff;
        act        = 2'h0;
        for (c = 0; c < NCH; c = c + 1) begin
            nxt_cnt[c] = cnt_ff[c];
            nxt_gra[c] = gra_ff[c];
            nxt_grb[c] = grb_ff[c];
            psc = ctrl_ff[c][`CTRL_PSC_LSB +: 3];
            case (psc)
                3'h0:    tick[c] = 1'b1;
                3'h1:    tick[c] = div_ff[0];
                3'h2:    tick[c] = &div_ff[1:0];
                3'h3:    tick[c] = &div_ff;
                default: tick[c] = ext_edge(ext_s2_ff[psc[1:0]], ext_s3_ff[psc[1:0]],
                                            ctrl_ff[c][`CTRL_EDGE_LSB +: 2]);
            endcase
            tick[c]    = tick[c] & run_ff[c];
            // match sampled while the counter is about to leave the value
            match_a[c] = tick[c] && (cnt_ff[c] == gra_ff[c]);
            match_b[c] = tick[c] && (cnt_ff[c] == grb_ff[c]);
            if (rs_mode && (c == 4)) begin
                match_a[c] = 1'b0;
                match_b[c] = 1'b0;
            end
            case (ctrl_ff[c][`CTRL_CLR_LSB +: 2])
                `CLR_ON_A: own_clr[c] = match_a[c];
                `CLR_ON_B: own_clr[c] = match_b[c];
                default:   own_clr[c] = 1'b0;
            endcase
            if (rs_mode && (c == 3)) begin
                own_clr[c] = match_a[c];
            end
        end
        sync_clr = |(sync_ff & own_clr);
        for (c = 0; c < NCH; c = c + 1) begin
            clr[c] = own_clr[c] || (sync_ff[c] && run_ff[c] && sync_clr &&
                     (ctrl_ff[c][`CTRL_CLR_LSB +: 2] == `CLR_SYNC));
            if (clr[c]) begin
                nxt_cnt[c] = `RST_COUNT;
            end else if (tick[c]) begin
                nxt_cnt[c] = cnt_ff[c] + 16'h0001;
            end
            // sync preset: one write reaches every synchronized counter
            if (ch_wr && (idx == `IDX_COUNT) &&
                (ch_onehot[c] || (sync_ff[c] && |(sync_ff & ch_onehot)))) begin
                nxt_cnt[c] = pwdata[15:0];
            end
            // pin a: pwm or plain compare output
            if (mode_ff[c]) begin
                if (match_a[c] && match_b[c]) begin
                    nxt_wave_a[c] = wave_a_ff[c];
                end else if (match_b[c]) begin
                    nxt_wave_a[c] = 1'b0;
                end else if (match_a[c]) begin
                    nxt_wave_a[c] = 1'b1;
                end
            end else if (match_a[c]) begin
                act = io_ff[c][`IO_PINA_LSB +: 2];
                case (act)
                    `ACT_LOW:    nxt_wave_a[c] = 1'b0;
                    `ACT_HIGH:   nxt_wave_a[c] = 1'b1;
                    `ACT_TOGGLE: nxt_wave_a[c] = ~wave_a_ff[c];
                    default:     nxt_wave_a[c] = wave_a_ff[c];
                endcase
            end
            // pin b keeps its io setting in pwm mode too
            if (match_b[c]) begin
                act = io_ff[c][`IO_PINB_LSB +: 2];
                case (act)
                    `ACT_LOW:    nxt_wave_b[c] = 1'b0;
                    `ACT_HIGH:   nxt_wave_b[c] = 1'b1;
                    `ACT_TOGGLE: nxt_wave_b[c] = ~wave_b_ff[c];
                    default:     nxt_wave_b[c] = wave_b_ff[c];
                endcase
            end
        end
        // reset-synchronized pwm: pairs follow the channel 3 count only
        pair_t2 = tick[3] && (cnt_ff[3] == gra_ff[4]);
        pair_t3 = tick[3] && (cnt_ff[3] == grb_ff[4]);
        if (rs_mode) begin
            nxt_pair[0] = pair_ff[0] ^ (match_b[3] | clr[3]);
            nxt_pair[1] = pair_ff[1] ^ (pair_t2 | clr[3]);
            nxt_pair[2] = pair_ff[2] ^ (pair_t3 | clr[3]);
            if (buf_en && match_a[3]) begin
                nxt_gra[3] = bufa_ff[0];
                nxt_grb[3] = bufb_ff[0];
                nxt_gra[4] = bufa_ff[1];
                nxt_grb[4] = bufb_ff[1];
            end
        end
        for (c = 0; c < NCH; c = c + 1) begin
            if (ch_wr && ch_onehot[c] && (idx == `IDX_GEN_A)) begin
                nxt_gra[c] = pwdata[15:0];
            end
            if (ch_wr && ch_onehot[c] && (idx == `IDX_GEN_B)) begin
                nxt_grb[c] = pwdata[15:0];
            end
        end
        // pin drivers
        nxt_pin_a = nxt_wave_a;
        nxt_pin_b = nxt_wave_b;
        for (c = 0; c < NCH; c = c + 1) begin
            nxt_oe_n[c] = (io_ff[c][`IO_PINB_LSB +: 2] == `ACT_NONE);
        end
        nxt_aux_a = 1'b0;
        nxt_aux_b = 1'b0;
        if (rs_mode) begin
            // polarity: level select high makes the positive phase active high
            nxt_pin_a[3] = nxt_pair[0] ^ ~mode_ff[`MODE_LVL3_BIT];
            nxt_pin_b[3] = ~nxt_pin_a[3];
            nxt_pin_a[4] = nxt_pair[1] ^ ~mode_ff[`MODE_LVL4_BIT];
            nxt_aux_a    = ~nxt_pin_a[4];
            nxt_pin_b[4] = nxt_pair[2] ^ ~mode_ff[`MODE_LVL4_BIT];
            nxt_aux_b    = ~nxt_pin_b[4];
            nxt_oe_n[3]  = 1'b0;
            nxt_oe_n[4]  = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (is_glob) begin
            case (paddr)
                `OFS_START:      rd_data = {27'h0, run_ff};
                `OFS_SYNC:       rd_data = {27'h0, sync_ff};
                `OFS_MODE:       rd_data = {23'h0, mode_ff};
                `OFS_PIN_STATUS: rd_data = {15'h0, ch4_aux_out_b, ch4_aux_out_a,
                                            5'h00, chan_pin_b, chan_pin_a};
                default:         rd_err  = 1'b1;
            endcase
        end else if (is_chan) begin
            case (idx)
                `IDX_CTRL:  rd_data = {25'h0, ctrl_ff[ch]};
                `IDX_IO:    rd_data = {28'h0, io_ff[ch]};
                `IDX_COUNT: rd_data = {16'h0, cnt_ff[ch]};
                `IDX_GEN_A: rd_data = {16'h0, gra_ff[ch]};
                `IDX_GEN_B: rd_data = {16'h0, grb_ff[ch]};
                `IDX_BUFA:  begin
                    rd_data = has_buf ? {16'h0, bufa_ff[bsel]} : 32'h0000_0000;
                    rd_err  = ~has_buf;
                end
                `IDX_BUFB:  begin
                    rd_data = has_buf ? {16'h0, bufb_ff[bsel]} : 32'h0000_0000;
                    rd_err  = ~has_buf;
                end
                default:    rd_err  = 1'b1;
            endcase
        end else begin
            rd_err = 1'b1;
        end
        if (paddr[1:0] != 2'h0) begin
            rd_data = 32'h0000_0000;
            rd_err = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // sequential
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff          <= 5'h00;
            sync_ff         <= 5'h00;
            mode_ff         <= 9'h000;
            wave_a_ff       <= 5'h00;
            wave_b_ff       <= 5'h00;
            pair_ff         <= 3'h0;
            div_ff          <= 3'h0;
            ext_s1_ff       <= 4'h0;
            ext_s2_ff       <= 4'h0;
            ext_s3_ff       <= 4'h0;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            chan_pin_a      <= 5'h00;
            chan_pin_b      <= 5'h00;
            chan_pin_b_oe_n <= 5'h1F;
            ch4_aux_out_a   <= 1'b0;
            ch4_aux_out_b   <= 1'b0;
            for (r = 0; r < NCH; r = r + 1) begin
                ctrl_ff[r] <= 7'h00;
                io_ff[r]   <= 4'h0;
                cnt_ff[r]  <= `RST_COUNT;
                gra_ff[r]  <= `RST_GR;
                grb_ff[r]  <= `RST_GR;
            end
            for (r = 0; r < 2; r = r + 1) begin
                bufa_ff[r] <= `RST_GR;
                bufb_ff[r] <= `RST_GR;
            end
        end else begin
            // one wait state keeps every bus output straight from a flop
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && rd_err;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rd_data;
            end
            div_ff    <= div_ff + 3'h1;
            ext_s1_ff <= ext_clk_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            if (wr && is_glob && (paddr == `OFS_START)) begin
                run_ff <= pwdata[4:0];
            end
            if (wr && is_glob && (paddr == `OFS_SYNC)) begin
                sync_ff <= pwdata[4:0];
            end
            if (wr && is_glob && (paddr == `OFS_MODE)) begin
                mode_ff <= pwdata[8:0];
            end
            for (r = 0; r < NCH; r = r + 1) begin
                cnt_ff[r] <= nxt_cnt[r];
                gra_ff[r] <= nxt_gra[r];
                grb_ff[r] <= nxt_grb[r];
                if (ch_wr && ch_onehot[r] && (idx == `IDX_CTRL)) begin
                    ctrl_ff[r] <= pwdata[6:0];
                end
                if (ch_wr && ch_onehot[r] && (idx == `IDX_IO)) begin
                    io_ff[r] <= pwdata[3:0];
                end
            end
            if (ch_wr && has_buf && (idx == `IDX_BUFA)) begin
                bufa_ff[bsel] <= pwdata[15:0];
            end
            if (ch_wr && has_buf && (idx == `IDX_BUFB)) begin
                bufb_ff[bsel] <= pwdata[15:0];
            end
            wave_a_ff       <= nxt_wave_a;
            wave_b_ff       <= nxt_wave_b;
            pair_ff         <= nxt_pair;
            chan_pin_a      <= nxt_pin_a;
            chan_pin_b      <= nxt_pin_b;
            chan_pin_b_oe_n <= nxt_oe_n;
            ch4_aux_out_a   <= nxt_aux_a;
            ch4_aux_out_b   <= nxt_aux_b;
        end
    end

endmodule // timer_pwm

//--- include/timer_pwm_defines.vh
// register offsets, field positions and reset values of the timer block
`ifndef TIMER_PWM_DEFINES_VH
`define TIMER_PWM_DEFINES_VH

// ---------------------------------------------------------------
// global registers (byte offsets)
// ---------------------------------------------------------------
`define OFS_START          8'h00
`define OFS_SYNC           8'h04
`define OFS_MODE           8'h08
`define OFS_PIN_STATUS     8'h0C

// ---------------------------------------------------------------
// per-channel block: base = (channel + 1) * 0x20
// ---------------------------------------------------------------
`define CH_STRIDE_SHIFT    5
`define IDX_CTRL           3'h0
`define IDX_IO             3'h1
`define IDX_COUNT          3'h2
`define IDX_GEN_A          3'h3
`define IDX_GEN_B          3'h4
`define IDX_BUFA           3'h5
`define IDX_BUFB           3'h6

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define MODE_RSPWM_BIT     5
`define MODE_BUF_BIT       6
`define MODE_LVL3_BIT      7
`define MODE_LVL4_BIT      8
`define CTRL_PSC_LSB       0
`define CTRL_EDGE_LSB      3
`define CTRL_CLR_LSB       5
`define IO_PINB_LSB        0
`define IO_PINA_LSB        2

// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define CLR_NONE           2'h0
`define CLR_ON_A           2'h1
`define CLR_ON_B           2'h2
`define CLR_SYNC           2'h3
`define ACT_NONE           2'h0
`define ACT_LOW            2'h1
`define ACT_HIGH           2'h2
`define ACT_TOGGLE         2'h3
`define EDGE_RISE          2'h0
`define EDGE_FALL          2'h1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_GR             16'hFFFF
`define RST_COUNT          16'h0000

`endif
